// [gtu_map.svh]
/*
 * Register offsets, field positions, reset values and synchroniser
 * counts of the general timer unit.
 * Assumes inclusion by bare name from the timer design files.
 */
`ifndef GTU_MAP_SVH
`define GTU_MAP_SVH

`define GTU_OFF_RELOAD 8'h00
`define GTU_OFF_CTRL 8'h04
`define GTU_OFF_IOCTL 8'h08
`define GTU_OFF_MODE 8'h0C
`define GTU_OFF_ISTAT 8'h10
`define GTU_OFF_IMASK 8'h14

`define GTU_CTRL_START 0
`define GTU_CTRL_ACTIVE 1
`define GTU_CTRL_EDGE 4
`define GTU_CTRL_UNDF 5
`define GTU_IOCTL_POL 0
`define GTU_IRQ_EDGE 0
`define GTU_IRQ_UNDF 1

`define GTU_RST_MODE 2'h0
`define GTU_RST_MASK 2'h0
`define GTU_RST_COUNT 16'h0000

`define GTU_START_LAST 2'h2
`define GTU_RELOAD_LAST 2'h2
`define GTU_EDGE_CLR_LAST 2'h1

`define GTU_RESP_OKAY 2'h0
`define GTU_RESP_SLVERR 2'h2

`endif

// [gtu_pkg.sv]
/*
 * Types shared by the general timer unit.
 * Assumes compilation before every timer design file.
 */
package gtu_pkg;

    typedef enum logic [1:0] {
        GTU_TIMER = 2'h0,
        GTU_EVENT = 2'h1,
        GTU_PWIDTH = 2'h2,
        GTU_PPERIOD = 2'h3
    } gtu_mode_e;

    typedef struct packed {
        logic src_tick;
        logic pin_rise;
        logic pin_fall;
        logic pin_level;
    } gtu_edges_s;

    typedef struct packed {
        logic [3:0] strb;
        logic [31:0] data;
        logic [7:0] addr;
    } gtu_wr_s;

endpackage : gtu_pkg

// [gtu_edge.sv]
/*
 * Edge finder for the count source and the measured pin.
 * Assumes both inputs are synchronous to sys_clk.
 */
`timescale 1ns/100ps

module gtu_edge (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic count_src,
    input wire logic event_pin,
    output gtu_pkg::gtu_edges_s edges
);

    logic src_q;
    logic pin_q;

    ////////////////////////////////////////////////////////////////////////
    // A count source cycle ends on each rising edge of the source.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            src_q <= 1'b0;
            pin_q <= 1'b0;
        end else begin
            src_q <= count_src;
            pin_q <= event_pin;
        end
    end

    assign edges.src_tick = count_src && !src_q;
    assign edges.pin_rise = event_pin && !pin_q;
    assign edges.pin_fall = !event_pin && pin_q;
    assign edges.pin_level = event_pin;

endmodule : gtu_edge

// [gtu_timer.sv]
/*
 * General timer unit with start and stop synchronisation, measurement
 * flags, paced counter writes and an AXI4-Lite register slave.
 * Assumes count_src and event_pin are synchronous to sys_clk and that
 * gtu_map.svh and gtu_pkg are available.
 */
// Implementation choices: register access over AXI4-Lite and the register offsets.
// Behaviour
// - Reset leaves timer stopped until software starts.
// - Active status rises two to three cycles late.
// - Counting begins on first edge after active.
// - Active status falls two to three cycles late.
// - Measurement flags clear on zero, ignore one.
// - Edge flag reads zero; internal lingers.
// - Edge during lingering keeps internal flag set.
// - Edge interrupt only on internal flag rising.
// - Counter write: direct stopped, delayed running.
`timescale 1ns/100ps
`include "gtu_map.svh"

module gtu_timer #(
    parameter int CW = 16
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic count_src,
    input wire logic event_pin,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    // Byte-lane merge and address decode.
    function automatic logic [CW-1:0] merge(input logic [CW-1:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0] strb);
        logic [CW-1:0] res;
        res = old;
        for (int i = 0; i < CW; i++) begin
            if (strb[i / 8]) begin
                res[i] = data[i];
            end
        end
        return res;
    endfunction : merge

    function automatic logic mapped(input logic [7:0] addr);
        return addr == `GTU_OFF_RELOAD || addr == `GTU_OFF_CTRL
            || addr == `GTU_OFF_IOCTL || addr == `GTU_OFF_MODE
            || addr == `GTU_OFF_ISTAT || addr == `GTU_OFF_IMASK;
    endfunction : mapped

    logic [1:0] rst_pipe;
    logic rst_ok_n;
    gtu_pkg::gtu_edges_s edges;
    gtu_pkg::gtu_wr_s wr;
    logic aw_full;
    logic w_full;
    logic wr_fire;
    logic ar_hs;
    logic [31:0] rd_mux;
    logic start_req;
    logic active;
    logic [1:0] start_cnt;
    gtu_pkg::gtu_mode_e mode;
    logic pol;
    logic [1:0] mask;
    logic [1:0] stat;
    logic [1:0] next_stat;
    logic [CW-1:0] counter;
    logic [CW-1:0] reload;
    logic wr_pend;
    logic [CW-1:0] wr_val;
    logic [1:0] wr_cnt;
    logic load_pend;
    logic edge_int;
    logic edge_clr_pend;
    logic [1:0] edge_clr_cnt;
    logic undf;
    logic meas;
    logic act_edge;
    logic step;
    logic undf_evt;
    logic edge_evt;
    logic wr_ctrl;
    logic wr_count;
    logic stopped;

    ////////////////////////////////////////////////////////////////////////
    // Reset release through two flip-flops.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_ok_n = rst_pipe[1];

    gtu_edge u_edge (
        .sys_clk(sys_clk),
        .rst_n(rst_ok_n),
        .count_src(count_src),
        .event_pin(event_pin),
        .edges(edges)
    );

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write side: address and data taken in either order.
    always_ff @(posedge sys_clk or negedge rst_ok_n) begin
        if (!rst_ok_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            aw_full <= 1'b0;
            w_full <= 1'b0;
            wr <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `GTU_RESP_OKAY;
        end else begin
            s_axi_awready <= s_axi_awvalid && !s_axi_awready && !aw_full && !s_axi_bvalid;
            s_axi_wready <= s_axi_wvalid && !s_axi_wready && !w_full && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full <= 1'b1;
                wr.addr <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_full <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full <= 1'b1;
                wr.data <= s_axi_wdata;
                wr.strb <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_full <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(wr.addr) ? `GTU_RESP_OKAY : `GTU_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    assign wr_fire = aw_full && w_full && !s_axi_bvalid;
    assign wr_ctrl = wr_fire && wr.addr == `GTU_OFF_CTRL && wr.strb[0];
    assign wr_count = wr_fire && wr.addr == `GTU_OFF_RELOAD;

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read side.
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (s_axi_araddr)
            `GTU_OFF_RELOAD: rd_mux[CW-1:0] = counter;
            `GTU_OFF_CTRL: begin
                rd_mux[`GTU_CTRL_START] = start_req;
                rd_mux[`GTU_CTRL_ACTIVE] = active;
                rd_mux[`GTU_CTRL_EDGE] = edge_int && !edge_clr_pend;
                rd_mux[`GTU_CTRL_UNDF] = undf;
            end
            `GTU_OFF_IOCTL: rd_mux[`GTU_IOCTL_POL] = pol;
            `GTU_OFF_MODE: rd_mux[1:0] = mode;
            `GTU_OFF_ISTAT: rd_mux[1:0] = stat;
            `GTU_OFF_IMASK: rd_mux[1:0] = mask;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    assign ar_hs = s_axi_arvalid && s_axi_arready;

    always_ff @(posedge sys_clk or negedge rst_ok_n) begin
        if (!rst_ok_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `GTU_RESP_OKAY;
        end else begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (ar_hs) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= mapped(s_axi_araddr) ? `GTU_RESP_OKAY : `GTU_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode, polarity and mask registers.
    always_ff @(posedge sys_clk or negedge rst_ok_n) begin
        if (!rst_ok_n) begin
            mode <= gtu_pkg::GTU_TIMER;
            pol <= 1'b0;
            mask <= `GTU_RST_MASK;
        end else if (wr_fire && wr.strb[0]) begin
            if (wr.addr == `GTU_OFF_MODE) begin
                mode <= gtu_pkg::gtu_mode_e'(wr.data[1:0]);
            end
            if (wr.addr == `GTU_OFF_IOCTL) begin
                pol <= wr.data[`GTU_IOCTL_POL];
            end
            if (wr.addr == `GTU_OFF_IMASK) begin
                mask <= wr.data[1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Start and stop synchronisation on count source cycles.
    always_ff @(posedge sys_clk or negedge rst_ok_n) begin
        if (!rst_ok_n) begin
            start_req <= 1'b0;
            active <= 1'b0;
            start_cnt <= 2'h0;
        end else begin
            if (wr_ctrl) begin
                start_req <= wr.data[`GTU_CTRL_START];
            end
            if (start_req == active) begin
                start_cnt <= 2'h0;
            end else if (edges.src_tick) begin
                if (start_cnt == `GTU_START_LAST) begin
                    active <= start_req;
                    start_cnt <= 2'h0;
                end else begin
                    start_cnt <= start_cnt + 2'h1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Count step selection per mode.
    assign meas = mode == gtu_pkg::GTU_PWIDTH || mode == gtu_pkg::GTU_PPERIOD;
    assign act_edge = pol ? edges.pin_fall : edges.pin_rise;
    assign stopped = !start_req && !active;
    always_comb begin
        unique case (mode)
            gtu_pkg::GTU_EVENT: step = active && act_edge;
            gtu_pkg::GTU_PWIDTH: step = active && edges.src_tick && (edges.pin_level ^ pol);
            gtu_pkg::GTU_TIMER,
            gtu_pkg::GTU_PPERIOD: step = active && edges.src_tick;
        endcase
    end
    assign undf_evt = step && counter == '0;
    assign edge_evt = meas && active
        && (mode == gtu_pkg::GTU_PPERIOD ? act_edge : (pol ? edges.pin_rise : edges.pin_fall));

    ////////////////////////////////////////////////////////////////////////
    // Counter and reload register.
    always_ff @(posedge sys_clk or negedge rst_ok_n) begin
        if (!rst_ok_n) begin
            counter <= `GTU_RST_COUNT;
            reload <= `GTU_RST_COUNT;
            wr_pend <= 1'b0;
            wr_val <= `GTU_RST_COUNT;
            wr_cnt <= 2'h0;
            load_pend <= 1'b0;
        end else begin
            if (wr_count && stopped) begin
                reload <= merge(reload, wr.data, wr.strb);
                counter <= merge(reload, wr.data, wr.strb);
                wr_pend <= 1'b0;
                load_pend <= 1'b0;
            end else begin
                if (wr_count) begin
                    wr_pend <= 1'b1;
                    wr_val <= merge(reload, wr.data, wr.strb);
                    wr_cnt <= 2'h0;
                end else if (wr_pend && edges.src_tick) begin
                    if (wr_cnt == `GTU_RELOAD_LAST) begin
                        reload <= wr_val;
                        wr_pend <= 1'b0;
                        load_pend <= 1'b1;
                    end else begin
                        wr_cnt <= wr_cnt + 2'h1;
                    end
                end
                if (load_pend && edges.src_tick) begin
                    counter <= reload;
                    load_pend <= 1'b0;
                end else if (undf_evt) begin
                    counter <= reload;
                end else if (step) begin
                    counter <= counter - 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Edge-seen flag with its lingering internal signal.
    always_ff @(posedge sys_clk or negedge rst_ok_n) begin
        if (!rst_ok_n) begin
            edge_int <= 1'b0;
            edge_clr_pend <= 1'b0;
            edge_clr_cnt <= 2'h0;
        end else begin
            if (edge_evt) begin
                edge_int <= 1'b1;
                edge_clr_pend <= 1'b0;
            end else if (wr_ctrl && meas && !wr.data[`GTU_CTRL_EDGE]) begin
                edge_clr_pend <= edge_int;
                edge_clr_cnt <= 2'h0;
            end else if (edge_clr_pend && edges.src_tick) begin
                if (edge_clr_cnt == `GTU_EDGE_CLR_LAST) begin
                    edge_int <= 1'b0;
                    edge_clr_pend <= 1'b0;
                end else begin
                    edge_clr_cnt <= edge_clr_cnt + 2'h1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Underflow flag: a new underflow wins over a clear.
    always_ff @(posedge sys_clk or negedge rst_ok_n) begin
        if (!rst_ok_n) begin
            undf <= 1'b0;
        end else if (undf_evt) begin
            undf <= 1'b1;
        end else if (wr_ctrl && meas && !wr.data[`GTU_CTRL_UNDF]) begin
            undf <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky interrupt status, cleared by a read, and masked output.
    always_comb begin
        next_stat = stat;
        if (ar_hs && s_axi_araddr == `GTU_OFF_ISTAT) begin
            next_stat = 2'h0;
        end
        if (edge_evt && !edge_int) begin
            next_stat[`GTU_IRQ_EDGE] = 1'b1;
        end
        if (undf_evt) begin
            next_stat[`GTU_IRQ_UNDF] = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_ok_n) begin
        if (!rst_ok_n) begin
            stat <= 2'h0;
            irq <= 1'b0;
        end else begin
            stat <= next_stat;
            irq <= |(next_stat & mask);
        end
    end

endmodule : gtu_timer

// [gtu_timer_asserts.sv]
/*
 * Bus handshake checker for the general timer unit.
 * Assumes it is bound to gtu_timer and sees only its ports.
 */
`timescale 1ns/100ps

module gtu_timer_asserts #(
    parameter int CW = 16
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////////////
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence

    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    ////////////////////////////////////////////////////////////////////////////
    chk_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("awready held longer than one cycle");
    chk_w_pulse: assert property (s_axi_wready |=> !s_axi_wready)
        else $error("wready held longer than one cycle");
    chk_ar_pulse: assert property (s_axi_arready |=> !s_axi_arready)
        else $error("arready held longer than one cycle");
    chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before bready");
    chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read data dropped before rready");
    chk_b_after_write: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
        else $error("no write response two cycles after transfer");
    chk_r_after_read: assert property (s_rd_taken |=> s_axi_rvalid)
        else $error("no read data one cycle after address");
    chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address accepted while data pending");
    chk_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write address accepted while response pending");

endmodule : gtu_timer_asserts

bind gtu_timer gtu_timer_asserts #(.CW(CW)) u_chk (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready)
);

// [timer_start_stop_flag_sync_tb_top.sv]
/*
 * Self-checking bench for the general timer unit over AXI4-Lite.
 * Assumes gtu_map.svh and gtu_pkg are compiled and the checker is bound.
 */
`timescale 1ns/100ps
`include "gtu_map.svh"

module timer_start_stop_flag_sync_tb_top;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic count_src = 1'b0;
    logic event_pin = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [7:0] s_axi_araddr = 8'h00;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    logic irq;
    int num_errors = 0;
    int comparisons = 0;
    logic [31:0] rd_val;
    logic [1:0] rsp;

    always #10 sys_clk = ~sys_clk;

    gtu_timer #(.CW(16)) DUT (.sys_clk(sys_clk), .rst_n(rst_n), .count_src(count_src),
        .event_pin(event_pin), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq));

    ////////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("checks %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic guard(input int n);
        if (n > 200) begin
            num_errors++;
            $display("BAD bus wait expected answer seen none");
            end_sim();
        end
    endtask : guard

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        bit a_now, w_now, b_now;
        n = 0;
        b_now = 0;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!b_now) begin
            @(negedge sys_clk);
            guard(++n);
            a_now = s_axi_awready;
            w_now = s_axi_wready;
            b_now = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge sys_clk);
            if (a_now) s_axi_awvalid <= 1'b0;
            if (w_now) s_axi_wvalid <= 1'b0;
            if (b_now) s_axi_bready <= 1'b0;
        end
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        bit a_now, r_now;
        n = 0;
        r_now = 0;
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!r_now) begin
            @(negedge sys_clk);
            guard(++n);
            a_now = s_axi_arready;
            r_now = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge sys_clk);
            if (a_now) s_axi_arvalid <= 1'b0;
            if (r_now) s_axi_rready <= 1'b0;
        end
    endtask : axi_rd

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_wr(a, d, r);
        check("write response", {30'h0, r}, {30'h0, `GTU_RESP_OKAY});
    endtask : wr

    task automatic rc(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(a, d, r);
        check(what, d, exp);
    endtask : rc

    // Each tick is one count source cycle, with the source idle low between.
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge sys_clk) count_src <= 1'b1;
            repeat (4) @(posedge sys_clk);
            count_src <= 1'b0;
            repeat (4) @(posedge sys_clk);
        end
    endtask : tick

    task automatic pulse;
        @(posedge sys_clk) event_pin <= 1'b1;
        repeat (4) @(posedge sys_clk);
        event_pin <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask : pulse

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        for (int i = 0; i < 6; i++) begin
            rc("reset value", 8'(i * 4), 32'h0000_0000);
        end
        axi_rd(8'h18, rd_val, rsp);
        check("unmapped read", {rd_val[29:0], rsp}, {30'h0, `GTU_RESP_SLVERR});
        axi_wr(8'h18, 32'h0000_0001, rsp);
        check("unmapped write", {30'h0, rsp}, {30'h0, `GTU_RESP_SLVERR});
        $display("test reset and map done");

        wr(`GTU_OFF_RELOAD, 32'h0000_0014);
        rc("stopped load", `GTU_OFF_RELOAD, 32'h0000_0014);
        tick(2);
        rc("idle count", `GTU_OFF_RELOAD, 32'h0000_0014);
        wr(`GTU_OFF_CTRL, 32'h0000_0001);
        tick(2);
        rc("start sync", `GTU_OFF_CTRL, 32'h0000_0001);
        tick(1);
        rc("start active", `GTU_OFF_CTRL, 32'h0000_0003);
        rc("first count", `GTU_OFF_RELOAD, 32'h0000_0014);
        tick(1);
        rc("counting", `GTU_OFF_RELOAD, 32'h0000_0013);
        wr(`GTU_OFF_RELOAD, 32'h0000_0009);
        tick(3);
        rc("running load", `GTU_OFF_RELOAD, 32'h0000_0010);
        tick(1);
        rc("running reload", `GTU_OFF_RELOAD, 32'h0000_0009);
        wr(`GTU_OFF_CTRL, 32'h0000_0000);
        tick(2);
        rc("stop sync", `GTU_OFF_CTRL, 32'h0000_0002);
        tick(1);
        rc("stopped", `GTU_OFF_CTRL, 32'h0000_0000);
        rc("halt count", `GTU_OFF_RELOAD, 32'h0000_0006);
        tick(2);
        rc("halted", `GTU_OFF_RELOAD, 32'h0000_0006);
        $display("test start stop done");

        wr(`GTU_OFF_MODE, 32'h0000_0003);
        wr(`GTU_OFF_IOCTL, 32'h0000_0000);
        wr(`GTU_OFF_IMASK, 32'h0000_0001);
        wr(`GTU_OFF_RELOAD, 32'h0000_0002);
        wr(`GTU_OFF_CTRL, 32'h0000_0031);
        tick(6);
        rc("underflow set", `GTU_OFF_CTRL, 32'h0000_0023);
        rc("masked status", `GTU_OFF_ISTAT, 32'h0000_0002);
        check("masked irq", {31'h0, irq}, 32'h0000_0000);
        wr(`GTU_OFF_CTRL, 32'h0000_0011);
        rc("underflow clear", `GTU_OFF_CTRL, 32'h0000_0003);
        pulse();
        check("edge irq", {31'h0, irq}, 32'h0000_0001);
        rc("edge set", `GTU_OFF_CTRL, 32'h0000_0013);
        rc("edge status", `GTU_OFF_ISTAT, 32'h0000_0001);
        check("irq cleared", {31'h0, irq}, 32'h0000_0000);
        wr(`GTU_OFF_CTRL, 32'h0000_0021);
        rc("edge read zero", `GTU_OFF_CTRL, 32'h0000_0003);
        pulse();
        rc("edge kept", `GTU_OFF_CTRL, 32'h0000_0013);
        check("no irq", {31'h0, irq}, 32'h0000_0000);
        rc("no status", `GTU_OFF_ISTAT, 32'h0000_0000);
        wr(`GTU_OFF_CTRL, 32'h0000_0021);
        tick(3);
        rc("edge settled", `GTU_OFF_CTRL, 32'h0000_0023);
        rc("underflow status", `GTU_OFF_ISTAT, 32'h0000_0002);
        pulse();
        check("next irq", {31'h0, irq}, 32'h0000_0001);
        rc("next status", `GTU_OFF_ISTAT, 32'h0000_0001);
        $display("test measurement flags done");

        rst_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rc("reset stop", `GTU_OFF_CTRL, 32'h0000_0000);
        rc("reset count", `GTU_OFF_RELOAD, 32'h0000_0000);
        wr(`GTU_OFF_MODE, 32'h0000_0001);
        wr(`GTU_OFF_RELOAD, 32'h0000_0005);
        wr(`GTU_OFF_CTRL, 32'h0000_0031);
        tick(3);
        rc("event active", `GTU_OFF_CTRL, 32'h0000_0003);
        pulse();
        pulse();
        rc("event count", `GTU_OFF_RELOAD, 32'h0000_0003);
        wr(`GTU_OFF_MODE, 32'h0000_0002);
        event_pin <= 1'b1;
        tick(2);
        event_pin <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rc("width count", `GTU_OFF_RELOAD, 32'h0000_0001);
        rc("width edge", `GTU_OFF_CTRL, 32'h0000_0013);
        $display("test reset event width done");
        end_sim();
    end

endmodule : timer_start_stop_flag_sync_tb_top
